/* logic/fsc2_status_byte.sv */
// second status/control byte: rate, auto sleep, abort enable, wide bus, suspend flags
//
// Overview of operation
// R1 - reads during ultra sleep return all ones
// R2 - bit 7 selects rate, zero single, one dual; resets zero
// R3 - bits 6:5 pick after program/erase: 10 ultra, 01 sleep, 00 standby
// R4 - both auto sleep enables reset to zero
// R5 - host never writes both auto sleep enables as one
// R6 - auto ultra sleep enable clears on every ultra sleep entry
// R7 - auto ultra sleep forces single-line signalling within switch time
// R8 - auto sleep enable clears on every sleep entry
// R9 - sleep entry and exit keep bus width and rate
// R10 - host issues no suspend while either auto enable is set
// R11 - bit 4 gates abort command; zero ignores, one accepts
// R12 - abort enable changes only by write command or power cycle
// R13 - abort command leaves abort enable unchanged
// R14 - bit 3 enables wide bus; resets zero so start is single line
// R15 - host writes zero to reserved bit 2
// R16 - bit 1 reads one while program is suspended
// R17 - bit 0 reads one while any erase is suspended
// R18 - written data in suspend flag positions is ignored
// R19 - writes need write latch; latch clears when write completes or aborts
`timescale 1ns/1ps
`default_nettype none
`include "fsc2_params.svh"
module fsc2_status_byte
    import fsc2_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // command decoder
    input  wire logic       wr_stb_i,
    input  wire logic [7:0] wr_cmd_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       wr_abort_i,
    input  wire logic       rd_stb_i,
    input  wire logic       abort_cmd_i,
    input  wire logic       write_latch_i,
    // operation state
    input  wire logic       pe_start_i,
    input  wire logic       pe_done_i,
    input  wire logic       ultra_sleep_state_i,
    input  wire logic       sleep_enter_i,
    input  wire logic       ultra_enter_i,
    input  wire logic       prog_held_i,
    input  wire logic       erase_held_i,
    // outputs
    output logic [7:0]      rd_data_o,
    output logic            write_latch_clr_o,
    output logic            abort_accept_o,
    output logic            rate_select_o,
    output logic            wide_bus_en_o,
    output logic [1:0]      after_pe_o,
    output logic            go_sleep_o,
    output logic            go_ultra_o
);
    logic       rate_reg;
    logic       ultra_en_reg;
    logic       sleep_en_reg;
    logic       abort_en_reg;
    logic       wide_reg;
    logic       rsvd_reg;
    logic       force_spi;

    wire logic  wr_hit     = wr_stb_i && (wr_cmd_i == `FSC2_WRITE_CMD);
    wire logic  wr_take    = wr_hit && write_latch_i;                      // [R19]
    wire logic  rate_eff   = force_spi ? 1'b0 : rate_reg;                  // [R7]
    wire logic  wide_eff   = force_spi ? 1'b0 : wide_reg;                  // [R7]
    wire fsc2_after_t after_sel = fsc2_after_t'({ultra_en_reg, sleep_en_reg}); // [R3]
    wire logic [7:0] live_byte = {rate_eff, ultra_en_reg, sleep_en_reg, abort_en_reg,
                                  wide_eff, rsvd_reg, prog_held_i,         // [R16]
                                  erase_held_i};                           // [R17]
    wire logic [7:0] rd_next   = ultra_sleep_state_i ? `FSC2_ULTRA_READ_VAL  // [R1]
                                                     : live_byte;

    fsc2_switch_timer u_switch (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .start_i     (pe_start_i && ultra_en_reg),                          // [R7]
        .clear_i     (!ultra_sleep_state_i && pe_done_i && !ultra_en_reg),
        .force_spi_o (force_spi)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rate_reg     <= 1'b0;                                           // [R2]
            ultra_en_reg <= 1'b0;                                           // [R4]
            sleep_en_reg <= 1'b0;                                           // [R4]
            abort_en_reg <= 1'b0;                                           // [R11]
            wide_reg     <= 1'b0;                                           // [R14]
            rsvd_reg     <= 1'b0;
        end else begin
            if (wr_take) begin
                rate_reg     <= wr_data_i[`FSC2_BIT_RATE];                  // [R2]
                abort_en_reg <= wr_data_i[`FSC2_BIT_ABORT];                 // [R12] [R13]
                wide_reg     <= wr_data_i[`FSC2_BIT_WIDE];                  // [R14]
                rsvd_reg     <= wr_data_i[`FSC2_BIT_RSVD];
            end else if (force_spi) begin
                rate_reg <= 1'b0;                                           // [R7]
                wide_reg <= 1'b0;                                           // [R7]
            end
            // hardware clear wins over a coincident write
            if (ultra_enter_i)
                ultra_en_reg <= 1'b0;                                       // [R6]
            else if (wr_take)
                ultra_en_reg <= wr_data_i[`FSC2_BIT_AUTO_ULTRA_SLEEP_EN];
            if (sleep_enter_i)
                sleep_en_reg <= 1'b0;                                       // [R8] [R9]
            else if (wr_take)
                sleep_en_reg <= wr_data_i[`FSC2_BIT_AUTO_SLEEP_EN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_data_o         <= 8'h00;
            write_latch_clr_o <= 1'b0;
            abort_accept_o    <= 1'b0;
            rate_select_o     <= 1'b0;
            wide_bus_en_o     <= 1'b0;
            after_pe_o        <= 2'b00;
            go_sleep_o        <= 1'b0;
            go_ultra_o        <= 1'b0;
        end else begin
            if (rd_stb_i)
                rd_data_o <= rd_next;                                       // [R18]
            write_latch_clr_o <= (wr_hit && write_latch_i) || (wr_abort_i && write_latch_i); // [R19]
            abort_accept_o    <= abort_cmd_i && abort_en_reg;               // [R11]
            rate_select_o     <= rate_eff;
            wide_bus_en_o     <= wide_eff;
            after_pe_o        <= after_sel;
            go_sleep_o        <= pe_done_i && (after_sel == FSC2_AFTER_SLEEP);  // [R3]
            go_ultra_o        <= pe_done_i && (after_sel == FSC2_AFTER_ULTRA);  // [R3]
        end
    end
endmodule
`default_nettype wire

/* logic/fsc2_params.svh */
// constants for the second status/control byte
`ifndef FSC2_PARAMS_SVH
`define FSC2_PARAMS_SVH
`define FSC2_BIT_RATE        7
`define FSC2_BIT_AUTO_ULTRA_SLEEP_EN       6
`define FSC2_BIT_AUTO_SLEEP_EN        5
`define FSC2_BIT_ABORT       4
`define FSC2_BIT_WIDE        3
`define FSC2_BIT_RSVD        2
`define FSC2_BIT_PROG_HELD   1
`define FSC2_BIT_ERASE_HELD  0
`define FSC2_RESET_VAL       8'h00
`define FSC2_ULTRA_READ_VAL  8'hFF
`define FSC2_WRITE_CMD       8'h31
`define FSC2_SWITCH_TIME_NS  100
`define FSC2_CLK_PERIOD_NS   5
`define FSC2_SWITCH_CYC      ((`FSC2_SWITCH_TIME_NS) / (`FSC2_CLK_PERIOD_NS))
`define FSC2_CNT_W           8
`endif

/* logic/fsc2_pkg.sv */
// types for the second status/control byte
package fsc2_pkg;
    typedef enum logic [1:0] {
        FSC2_AFTER_STANDBY = 2'b00,
        FSC2_AFTER_SLEEP   = 2'b01,
        FSC2_AFTER_ULTRA   = 2'b10,
        FSC2_AFTER_ILLEGAL = 2'b11
    } fsc2_after_t;
    typedef enum logic [1:0] {
        FSC2_SW_IDLE = 2'b00,
        FSC2_SW_WAIT = 2'b01,
        FSC2_SW_DONE = 2'b10
    } fsc2_sw_t;
endpackage

/* logic/fsc2_switch_timer.sv */
// timer that forces single-line signalling after auto ultra sleep starts
`timescale 1ns/1ps
`default_nettype none
`include "fsc2_params.svh"
module fsc2_switch_timer
    import fsc2_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // control
    input  wire logic start_i,
    input  wire logic clear_i,
    // result
    output logic      force_spi_o
);
    localparam logic [`FSC2_CNT_W-1:0] CYC = (`FSC2_SWITCH_CYC < 1) ? `FSC2_CNT_W'(1)
                                           : `FSC2_CNT_W'(`FSC2_SWITCH_CYC);
    fsc2_sw_t                state_reg;
    fsc2_sw_t                state_next;
    logic [`FSC2_CNT_W-1:0]  cnt_reg;
    wire  logic              cnt_last = (cnt_reg == CYC - `FSC2_CNT_W'(1));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FSC2_SW_IDLE: if (start_i) state_next = FSC2_SW_WAIT;
            FSC2_SW_WAIT: if (clear_i) state_next = FSC2_SW_IDLE;
                          else if (cnt_last) state_next = FSC2_SW_DONE;
            FSC2_SW_DONE: if (clear_i) state_next = FSC2_SW_IDLE;
            default:      state_next = FSC2_SW_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg   <= FSC2_SW_IDLE;
            cnt_reg     <= '0;
            force_spi_o <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= (state_reg == FSC2_SW_WAIT) ? cnt_reg + `FSC2_CNT_W'(1) : '0;
            force_spi_o <= (state_next == FSC2_SW_DONE);
        end
    end
endmodule
`default_nettype wire

/* sim/fsc2_status_byte_chk.sv */
// assertions for the second status/control byte
`timescale 1ns/1ps
`default_nettype none
module fsc2_status_byte_chk (
    // clock, reset and requests
    input wire logic       clk_i, rst_n_i, wr_stb_i, write_latch_i, rd_stb_i, abort_cmd_i,
    input wire logic       pe_start_i, pe_done_i, ultra_sleep_state_i, sleep_enter_i,
    input wire logic       ultra_enter_i,
    input wire logic [7:0] wr_cmd_i, wr_data_i, rd_data_o,
    // observed outputs
    input wire logic       write_latch_clr_o, abort_accept_o, rate_select_o, go_sleep_o,
    input wire logic       go_ultra_o,
    input wire logic [1:0] after_pe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic wr_take = wr_stb_i && wr_cmd_i == 8'h31 && write_latch_i;
    logic      rate_exp;
    always_ff @(posedge clk_i) rate_exp <= wr_data_i[7];
    property p_ultra_rd; rd_stb_i && ultra_sleep_state_i |=> rd_data_o == 8'hFF; endproperty
    a_ultra_rd: assert property (p_ultra_rd) else $error("sleep read not ones");
    property p_rate; wr_take && !pe_start_i && !after_pe_o[1]
        |=> ##1 rate_select_o == $past(rate_exp);
    endproperty
    a_rate: assert property (p_rate) else $error("rate not written");
    property p_no_latch; wr_stb_i && !write_latch_i |=> !write_latch_clr_o; endproperty
    a_no_latch: assert property (p_no_latch) else $error("latch cleared w/o latch");
    property p_clr; wr_take |=> write_latch_clr_o; endproperty
    a_clr: assert property (p_clr) else $error("latch not cleared");
    property p_abort; abort_accept_o |-> $past(abort_cmd_i); endproperty
    a_abort: assert property (p_abort) else $error("abort accepted uncalled");
    property p_ultra_clr; ultra_enter_i |=> ##1 !after_pe_o[1]; endproperty
    a_ultra_clr: assert property (p_ultra_clr) else $error("ultra en kept");
    property p_sleep_clr; sleep_enter_i |=> ##1 !after_pe_o[0]; endproperty
    a_sleep_clr: assert property (p_sleep_clr) else $error("sleep en kept");
    property p_go; pe_done_i |=> {go_ultra_o, go_sleep_o} == $past(after_pe_o); endproperty
    a_go: assert property (p_go) else $error("wrong action after done");
    c_take: cover property (wr_take);
    c_go_ultra: cover property (go_ultra_o);
    c_abort: cover property (abort_accept_o);
endmodule
bind fsc2_status_byte fsc2_status_byte_chk u_fsc2_status_byte_chk (.*);
`default_nettype wire

/* sim/fsc2_host_model.sv */
// host controller issuing status byte writes and reads
`timescale 1ns/1ps
`default_nettype none
module fsc2_host_model (
    input  wire logic       clk_i,
    output logic            wr_stb_o, rd_stb_o,
    output logic [7:0]      wr_cmd_o, wr_data_o
);
    initial begin
        {wr_stb_o, rd_stb_o, wr_cmd_o, wr_data_o} = '0;
    end
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        @(posedge clk_i);
        wr_stb_o <= 1'b1;
        wr_cmd_o <= cmd;
        wr_data_o <= d & 8'hFB & {2'b11, ~d[6], 5'h1F};
        @(posedge clk_i);
        wr_stb_o <= 1'b0;
        wr_cmd_o <= ~wr_cmd_o;
        wr_data_o <= ~wr_data_o;
    endtask
    task automatic rd;
        @(posedge clk_i);
        rd_stb_o <= 1'b1;
        @(posedge clk_i);
        rd_stb_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* sim/fsc2_status_byte_tb.sv */
// self-checking bench for the second status/control byte
`timescale 1ns/1ps
`default_nettype none
module fsc2_status_byte_tb
    import fsc2_pkg::*;
;
    logic clk_i = 0, rst_n_i = 0, wr_abort_i = 0, abort_cmd_i = 0, write_latch_i = 0;
    logic pe_start_i = 0, pe_done_i = 0, ultra_sleep_state_i = 0, sleep_enter_i = 0;
    logic ultra_enter_i = 0, prog_held_i = 0, erase_held_i = 0, wr_stb_i, rd_stb_i;
    logic write_latch_clr_o, abort_accept_o, rate_select_o, wide_bus_en_o, go_sleep_o, go_ultra_o;
    logic [7:0] wr_cmd_i, wr_data_i, rd_data_o;
    logic [1:0] after_pe_o;
    int n_fail = 0, checked = 0, cyc = 0;
    always #2.5 clk_i = ~clk_i;
    fsc2_status_byte u_fsc2_status_byte (.*);
    fsc2_host_model u_fsc2_host_model (.clk_i, .wr_stb_o(wr_stb_i), .rd_stb_o(rd_stb_i),
        .wr_cmd_o(wr_cmd_i), .wr_data_o(wr_data_i));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] exp);
        u_fsc2_host_model.rd();
        #1 chk(rd_data_o, exp);
    endtask
    task automatic abort_chk(input logic exp);
        @(posedge clk_i); abort_cmd_i <= 1;
        @(posedge clk_i); abort_cmd_i <= 0;
        #1 chk(abort_accept_o, exp);
    endtask
    task automatic t_power_up;
        rd(8'h00);
        abort_chk(0);
    endtask
    task automatic t_write;
        u_fsc2_host_model.wr(8'h31, 8'hFF);
        #1 chk(write_latch_clr_o, 1);
        @(posedge clk_i);
        #1 chk({rate_select_o, wide_bus_en_o, after_pe_o}, 4'b1110);
        rd(8'hD8);
        abort_chk(1);
        rd(8'hD8);
    endtask
    task automatic t_refuse;
        @(posedge clk_i); write_latch_i <= 0;
        u_fsc2_host_model.wr(8'h31, 8'h00);
        #1 chk(write_latch_clr_o, 0);
        @(posedge clk_i); write_latch_i <= 1;
        u_fsc2_host_model.wr(8'h30, 8'h00);
        rd(8'hD8);
        @(posedge clk_i); wr_abort_i <= 1;
        @(posedge clk_i); wr_abort_i <= 0;
        #1 chk(write_latch_clr_o, 1);
        u_fsc2_host_model.wr(8'h31, 8'h00);
        abort_chk(0);
    endtask
    task automatic t_flags;
        @(posedge clk_i); prog_held_i <= 1;
        rd(8'h02);
        @(posedge clk_i); {prog_held_i, erase_held_i} <= 2'b01;
        rd(8'h01);
        @(posedge clk_i); erase_held_i <= 0;
    endtask
    task automatic t_modes;
        for (int i = 0; i < 3; i++) begin
            u_fsc2_host_model.wr(8'h31, {1'b1, 2'(i), 5'h08});
            @(posedge clk_i); pe_start_i <= 1;
            @(posedge clk_i); pe_start_i <= 0;
            repeat (22) @(posedge clk_i);
            #1 if (i == 2) chk({rate_select_o, wide_bus_en_o}, 0);
            @(posedge clk_i); pe_done_i <= 1;
            @(posedge clk_i); pe_done_i <= 0;
            #1 chk({go_ultra_o, go_sleep_o}, 8'(i));
            @(posedge clk_i); {ultra_enter_i, sleep_enter_i} <= 2'(i);
            @(posedge clk_i); {ultra_enter_i, sleep_enter_i} <= 2'b00;
            @(posedge clk_i);
            #1 chk(after_pe_o, 0);
            if (i == 1) chk({rate_select_o, wide_bus_en_o}, 3);
        end
        @(posedge clk_i); ultra_sleep_state_i <= 1;
        rd(8'hFF);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            finish_test;
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1;
        write_latch_i <= 1;
        t_power_up;
        t_write;
        t_refuse;
        t_flags;
        t_modes;
        finish_test;
    end
endmodule
`default_nettype wire
